// ---- brs_pkg.sv ----
// Purpose: shared constants and types for the brown-out reset sequencer
// Assumes: 25 MHz system clock
// Notes:   register offsets are indexes on the plain register port
package brs_pkg;
    // register map
    localparam logic [3:0] ADDR_RCAUSE  = 4'h0; // reset cause register
    localparam logic [3:0] ADDR_OSCCTL  = 4'h1; // osc control register
    localparam logic [3:0] ADDR_CALIB   = 4'h2; // clock calibration register
    localparam logic [3:0] ADDR_NVCTL   = 4'h3; // nonvolatile control register
    localparam logic [3:0] ADDR_CFG     = 4'h4; // reset config word (read only)
    localparam logic [3:0] ADDR_STAT    = 4'h5; // sequencer state (read only)
    // reset config word fields
    localparam int CFG_LEVEL_LSB = 5;
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_POWER_UP_TIMER_BIT  = 7;
    // reset cause register fields
    localparam int RC_POR_BIT    = 0;
    localparam int RC_BOR_BIT    = 1;
    localparam int RC_SWRST_BIT  = 6;
    localparam int RC_SOFTWARE_BROWNOUT_ENABLE_BIT = 13;
    // reset values
    localparam logic [15:0] RCAUSE_POR_VAL = 16'h0003;
    localparam logic [15:0] CALIB_RST_VAL  = 16'h0000;
    localparam logic [15:0] NVCTL_RST_VAL  = 16'h0000;
    // oscillator selects
    localparam logic [2:0] OSC_FRC  = 3'h0;
    localparam logic [2:0] OSC_LOW_POWER_RC_OSC = 3'h5;
    // timing
    localparam int CLK_HZ          = 25_000_000;
    localparam int POWER_UP_TIMER_US         = 64;
    localparam int POWER_UP_TIMER_CYC        = (POWER_UP_TIMER_US * (CLK_HZ / 1_000_000));
    localparam int CLKMON_WIN_CYC  = 16;

    typedef enum logic [1:0] {
        BM_OFF   = 2'b00,
        BM_SOFT  = 2'b01,
        BM_NOSLP = 2'b10,
        BM_HW    = 2'b11
    } brs_bormode_t;

    typedef struct packed {
        logic [1:0]   level;    // brown-out trip point select
        brs_bormode_t mode;     // brown-out enable mode
        logic         power_up_timer_en;  // power-up timer enable
        logic [2:0]   init_osc; // initial osc select
        logic         clkmon_en;
    } brs_cfg_t;

    typedef enum logic [1:0] {
        ST_BOR  = 2'b00,
        ST_POWER_UP_TIMER = 2'b01,
        ST_WCLK = 2'b10,
        ST_RUN  = 2'b11
    } brs_state_t;
endpackage

// ---- brs_sync.sv ----
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: width is small
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module brs_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    input  wire logic         resetn,
    // data
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // two stages, reset to zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule

// ---- brs_power_up_timer.sv ----
// Purpose: power-up delay counter
// Assumes: restart reloads the full delay
// Notes:   done is a level held until restart
`timescale 1ns/1ps
module brs_power_up_timer #(
    parameter int CYC = 1600
) (
    // clock
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // control
    input  wire logic restart,
    input  wire logic run,
    output logic      done
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    // count up while running, restart clears the count
    always_comb begin
        cnt_d = cnt_q;
        if (restart) begin
            cnt_d = 32'h0;
        end else if (run && cnt_q < CYC) begin
            cnt_d = cnt_q + 32'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= 32'h0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end
    assign done = (cnt_q >= CYC);
endmodule

// ---- brs_top.sv ----
// Purpose: brown-out reset sequencer with clock-fail monitor
// Assumes: resetn is the power-on reset; other causes arrive as pulses
// Notes:   registers are indexed words on a plain strobe port
//
// Behaviour
// - execution held until clock released
// - clock monitor starts a cycle after reset release
// - no clock at start: switch to fast RC
// - clock failure later: switch to low-power RC
// - other registers reset uniformly
// - cause register reset value depends on cause
// - osc control reset uses type and select
// - calibration, nonvolatile control: power-on only
// - level 6:5, mode 1:0 in config word
// - level selects 1.8V, 2.7V, 3.0V trip
// - mode not 00: undervoltage asserts reset
// - hold reset while supply below threshold
// - power-up timer extends after recovery
// - dip during timer restarts full delay
// - timer enable independent of brown-out enable
// - mode 01: software enable bit 13
// - mode 10: disabled in Sleep
// - brown-out flag set on brown-out, power-on
// - deep sleep exit sets both flags
`timescale 1ns/1ps
module brs_top #(
    parameter int POWER_UP_TIMER_CYC = brs_pkg::POWER_UP_TIMER_CYC
) (
    // clock and power-on reset
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            ce,
    // configuration words
    input  wire logic [15:0]     reset_config_word,
    input  wire logic [2:0]      initial_osc_select,
    input  wire logic            clkmon_enable,
    // analog and clock status, asynchronous
    input  wire logic            supply_below,
    input  wire logic            clock_valid,
    // operating mode and other reset causes
    input  wire logic            sleep_mode,
    input  wire logic            deep_sleep_exit,
    input  wire logic            sw_reset,
    // register port
    input  wire logic [3:0]      reg_addr,
    input  wire logic [15:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [15:0]          reg_rdata,
    // outputs
    output logic                 internal_system_reset,
    output logic                 exec_enable,
    output logic [1:0]           trip_level,
    output logic                 clk_switch_req,
    output logic [2:0]           clk_switch_sel
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    brs_pkg::brs_cfg_t cfg;

    // fields of the reset config word
    always_comb begin
        cfg.level     = reset_config_word[brs_pkg::CFG_LEVEL_LSB +: 2];
        cfg.mode      = brs_pkg::brs_bormode_t'(reset_config_word[brs_pkg::CFG_MODE_LSB +: 2]);
        cfg.power_up_timer_en   = reset_config_word[brs_pkg::CFG_POWER_UP_TIMER_BIT];
        cfg.init_osc  = initial_osc_select;
        cfg.clkmon_en = clkmon_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronised asynchronous inputs
    logic [1:0] as_s;

    brs_sync #(.W(2)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({clock_valid, supply_below}),
        .q      (as_s)
    );
    logic low_s;
    logic cvalid_s;
    assign low_s    = as_s[0];
    assign cvalid_s = as_s[1];

    ////////////////////////////////////////////////////////////////////////////
    // brown-out enable
    logic rc_software_brownout_enable_q;
    logic bor_en;

    // effective enable per mode
    always_comb begin
        unique case (cfg.mode)
            brs_pkg::BM_OFF:   bor_en = 1'b0;
            brs_pkg::BM_SOFT:  bor_en = rc_software_brownout_enable_q;
            brs_pkg::BM_NOSLP: bor_en = !sleep_mode;
            brs_pkg::BM_HW:    bor_en = 1'b1;
        endcase
    end
    logic bor_trip;
    assign bor_trip = bor_en && low_s;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    brs_pkg::brs_state_t st_q;
    brs_pkg::brs_state_t st_d;
    logic                power_up_timer_done;
    logic                power_up_timer_restart;

    // the power-up timer is re-armed on every trip, so a dip costs a full delay
    brs_power_up_timer #(.CYC(POWER_UP_TIMER_CYC)) u_power_up_timer (
        .clk     (clk),
        .resetn  (resetn),
        .ce      (ce),
        .restart (power_up_timer_restart),
        .run     (st_q == brs_pkg::ST_POWER_UP_TIMER),
        .done    (power_up_timer_done)
    );

    // next state
    always_comb begin
        st_d         = st_q;
        power_up_timer_restart = 1'b0;
        if (bor_trip) begin
            st_d         = brs_pkg::ST_BOR;
            power_up_timer_restart = 1'b1;
        end else begin
            unique case (st_q)
                brs_pkg::ST_BOR: begin
                    // leave in any cycle without bor_trip: supply above threshold or brown-out not enabled
                    st_d = cfg.power_up_timer_en ? brs_pkg::ST_POWER_UP_TIMER : brs_pkg::ST_WCLK;
                    power_up_timer_restart = 1'b1;
                end
                brs_pkg::ST_POWER_UP_TIMER: begin
                    if (power_up_timer_done) begin
                        st_d = brs_pkg::ST_WCLK;
                    end
                end
                brs_pkg::ST_WCLK: begin
                    if (cvalid_s || clk_switch_req) begin
                        st_d = brs_pkg::ST_RUN;
                    end
                end
                brs_pkg::ST_RUN: st_d = brs_pkg::ST_RUN;
            endcase
        end
    end

    // a software reset replays the release sequence without a delay
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= brs_pkg::ST_BOR;
        end else if (ce) begin
            st_q <= sw_reset ? brs_pkg::ST_WCLK : st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs and clock-fail monitor
    logic       internal_system_reset_d;
    logic       exec_d;
    logic       sw_req_d;
    logic [2:0] sw_sel_d;
    logic       released;
    logic       mon_arm_q;

    // monitor runs a cycle after release: the clock-valid sync is still
    // filling right after power-on and would fake a missing clock
    assign released = !internal_system_reset && mon_arm_q;

    always_comb begin
        internal_system_reset_d = (st_d == brs_pkg::ST_BOR) || (st_d == brs_pkg::ST_POWER_UP_TIMER);
        exec_d   = (st_d == brs_pkg::ST_RUN) && !internal_system_reset_d;
        sw_req_d = clk_switch_req;
        sw_sel_d = clk_switch_sel;
        if (internal_system_reset_d) begin
            sw_req_d = 1'b0;
            sw_sel_d = cfg.init_osc;
        end else if (cfg.clkmon_en && released && !cvalid_s && !clk_switch_req) begin
            sw_req_d = 1'b1;
            // no clock at start goes to fast RC, later failure to low-power RC
            sw_sel_d = (st_q == brs_pkg::ST_RUN) ? brs_pkg::OSC_LOW_POWER_RC_OSC : brs_pkg::OSC_FRC;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            internal_system_reset <= 1'b1;
            exec_enable           <= 1'b0;
            clk_switch_req        <= 1'b0;
            clk_switch_sel        <= brs_pkg::OSC_FRC;
            trip_level            <= 2'h0;
            mon_arm_q             <= 1'b0;
        end else if (ce) begin
            internal_system_reset <= internal_system_reset_d;
            exec_enable           <= exec_d;
            clk_switch_req        <= sw_req_d;
            clk_switch_sel        <= sw_sel_d;
            trip_level            <= cfg.level;
            mon_arm_q             <= !internal_system_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers with reset-type dependent values
    logic [15:0] rcause_q;
    logic [15:0] rcause_d;
    logic [15:0] oscctl_q;
    logic [15:0] oscctl_d;
    logic [15:0] calib_q;
    logic [15:0] calib_d;
    logic [15:0] nvctl_q;
    logic [15:0] nvctl_d;
    logic        wr_rc;

    assign wr_rc       = reg_wr && (reg_addr == brs_pkg::ADDR_RCAUSE);
    assign rc_software_brownout_enable_q = rcause_q[brs_pkg::RC_SOFTWARE_BROWNOUT_ENABLE_BIT];

    // software writes first, hardware events win over a clear
    always_comb begin
        rcause_d = rcause_q;
        oscctl_d = oscctl_q;
        calib_d  = calib_q;
        nvctl_d  = nvctl_q;
        if (wr_rc) begin
            rcause_d = reg_wdata;
        end
        if (reg_wr && reg_addr == brs_pkg::ADDR_OSCCTL) begin
            oscctl_d = reg_wdata;
        end
        if (reg_wr && reg_addr == brs_pkg::ADDR_CALIB) begin
            calib_d = reg_wdata;
        end
        if (reg_wr && reg_addr == brs_pkg::ADDR_NVCTL) begin
            nvctl_d = reg_wdata;
        end
        if (cfg.mode != brs_pkg::BM_SOFT) begin
            rcause_d[brs_pkg::RC_SOFTWARE_BROWNOUT_ENABLE_BIT] = 1'b0;
        end
        if (bor_trip) begin
            rcause_d[brs_pkg::RC_BOR_BIT] = 1'b1;
        end
        if (deep_sleep_exit) begin
            rcause_d[brs_pkg::RC_POR_BIT] = 1'b1;
            rcause_d[brs_pkg::RC_BOR_BIT] = 1'b1;
        end
        if (sw_reset) begin
            rcause_d[brs_pkg::RC_SWRST_BIT] = 1'b1;
            oscctl_d = {13'h0, cfg.init_osc};
        end
        // the switch the monitor made is shown in the current-osc field
        if (sw_req_d && !clk_switch_req) begin
            oscctl_d[14:12] = sw_sel_d;
        end
    end

    // power-on loads all; calibration and nonvolatile control only here
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rcause_q <= brs_pkg::RCAUSE_POR_VAL;
            oscctl_q <= {13'h0, cfg.init_osc};
            calib_q  <= brs_pkg::CALIB_RST_VAL;
            nvctl_q  <= brs_pkg::NVCTL_RST_VAL;
        end else if (ce) begin
            rcause_q <= rcause_d;
            oscctl_q <= oscctl_d;
            calib_q  <= calib_d;
            nvctl_q  <= nvctl_d;
        end
    end

    // strap the initial osc select into osc control once after power-on
    logic por_seen_q;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            por_seen_q <= 1'b0;
        end else begin
            por_seen_q <= 1'b1;
        end
    end
    logic [15:0] oscctl_rd;
    assign oscctl_rd = por_seen_q ? oscctl_q : {13'h0, cfg.init_osc};

    ////////////////////////////////////////////////////////////////////////////
    // read port
    logic [15:0] rdata_d;

    // unmapped addresses read zero; other registers reset uniformly
    always_comb begin
        unique case (reg_addr)
            brs_pkg::ADDR_RCAUSE: rdata_d = rcause_q;
            brs_pkg::ADDR_OSCCTL: rdata_d = oscctl_rd;
            brs_pkg::ADDR_CALIB:  rdata_d = calib_q;
            brs_pkg::ADDR_NVCTL:  rdata_d = nvctl_q;
            brs_pkg::ADDR_CFG:    rdata_d = reset_config_word;
            brs_pkg::ADDR_STAT:   rdata_d = {14'h0, st_q};
            default:              rdata_d = 16'h0;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 16'h0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rdata_d : 16'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_exec_after_rst;
        @(posedge clk) disable iff (!resetn)
        exec_enable |-> !internal_system_reset;
    endproperty
    a_exec_after_rst: assert property (p_exec_after_rst) else $error("exec during reset");

    property p_trip_holds;
        @(posedge clk) disable iff (!resetn)
        (ce && bor_trip) |=> internal_system_reset;
    endproperty
    a_trip_holds: assert property (p_trip_holds) else $error("brown-out missed");

    property p_flag_set;
        @(posedge clk) disable iff (!resetn)
        (ce && bor_trip) |=> rcause_q[1];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_software_brownout_enable_zero;
        @(posedge clk) disable iff (!resetn)
        (ce && cfg.mode != brs_pkg::BM_SOFT && $stable(cfg.mode)) |=> !rcause_q[13];
    endproperty
    a_software_brownout_enable_zero: assert property (p_software_brownout_enable_zero) else $error("soft bit not zero");

    property p_ds_flags;
        @(posedge clk) disable iff (!resetn)
        (ce && deep_sleep_exit) |=> (rcause_q[0] && rcause_q[1]);
    endproperty
    a_ds_flags: assert property (p_ds_flags) else $error("deep sleep flags");

    property p_off_no_trip;
        @(posedge clk) disable iff (!resetn)
        (cfg.mode == brs_pkg::BM_OFF) |-> !bor_trip;
    endproperty
    a_off_no_trip: assert property (p_off_no_trip) else $error("trip with mode off");

    property p_sleep_off;
        @(posedge clk) disable iff (!resetn)
        (cfg.mode == brs_pkg::BM_NOSLP && sleep_mode) |-> !bor_en;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("enabled in sleep");

    property p_hw_on;
        @(posedge clk) disable iff (!resetn)
        (cfg.mode == brs_pkg::BM_HW) |-> bor_en;
    endproperty
    a_hw_on: assert property (p_hw_on) else $error("mode 11 disabled");

    property p_no_power_up_timer;
        @(posedge clk) disable iff (!resetn)
        (ce && !cfg.power_up_timer_en && st_q == brs_pkg::ST_BOR && !bor_trip && !sw_reset)
            |=> st_q == brs_pkg::ST_WCLK;
    endproperty
    a_no_power_up_timer: assert property (p_no_power_up_timer) else $error("timer not independent");
endmodule

// ---- brs_tb_top.sv ----
// Purpose: self-checking bench for the brown-out reset sequencer
// Assumes: timer shortened to 8 cycles, ce held high throughout
// Notes:   random dip lengths and field values from a fixed seed
`timescale 1ns/1ps
module tb_top;
    localparam int PW = 8;
    logic        clk, resetn, ce, clkmon_enable, supply_below, clock_valid;
    logic        sleep_mode, deep_sleep_exit, sw_reset, reg_wr, reg_rd;
    logic [15:0] reset_config_word, reg_wdata, reg_rdata, rv, dcal;
    logic [2:0]  initial_osc_select, clk_switch_sel;
    logic [3:0]  reg_addr;
    logic [1:0]  trip_level, lvl;
    logic        internal_system_reset, exec_enable, clk_switch_req, e;
    int          errors, checks, cyc, n;

    brs_top #(.POWER_UP_TIMER_CYC(PW)) uut (
        .clk(clk), .resetn(resetn), .ce(ce), .reset_config_word(reset_config_word),
        .initial_osc_select(initial_osc_select), .clkmon_enable(clkmon_enable),
        .supply_below(supply_below), .clock_valid(clock_valid), .sleep_mode(sleep_mode),
        .deep_sleep_exit(deep_sleep_exit), .sw_reset(sw_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .internal_system_reset(internal_system_reset), .exec_enable(exec_enable),
        .trip_level(trip_level), .clk_switch_req(clk_switch_req),
        .clk_switch_sel(clk_switch_sel));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 20000) begin
            errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [15:0] mk_cfg(input logic [1:0] l, input logic [1:0] m,
                                           input logic p);
        return (16'(l) << 5) | 16'(m) | (16'(p) << 7);
    endfunction

    // brown-out live only if mode, soft bit and sleep all permit it
    function automatic logic trips(input logic [1:0] m, input logic sb, input logic slp);
        return (m != 2'b00) && (m != 2'b01 || sb) && !(m == 2'b10 && slp);
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0, got}, {15'h0, exp});
    endtask

    // a count of cycles must fall inside a window
    task automatic chk_cnt(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // register port and sequencing tasks
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_rst(input logic v, output int k);
        k = 0;
        while (internal_system_reset !== v && k < 80) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic por(input logic [15:0] cfg, input logic cv, input logic mon);
        @(posedge clk);
        reset_config_word <= cfg;
        clock_valid       <= cv;
        clkmon_enable     <= mon;
        supply_below      <= 1'b0;
        resetn            <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk_bit(internal_system_reset, 1'b1);
        chk_bit(exec_enable | clk_switch_req, 1'b0);
        @(posedge clk);
        resetn <= 1'b1;
    endtask

    // supply dip of given length; reset seen at its end is compared
    task automatic dip(input int hold, input logic exp, output int k);
        @(posedge clk);
        supply_below <= 1'b1;
        repeat (hold) @(posedge clk);
        #1;
        chk_bit(internal_system_reset, exp);
        @(posedge clk);
        supply_below <= 1'b0;
        wait_rst(1'b0, k);
    endtask

    task automatic pulse_sw(input logic which);
        @(posedge clk);
        if (which) sw_reset <= 1'b1;
        else deep_sleep_exit <= 1'b1;
        @(posedge clk);
        sw_reset        <= 1'b0;
        deep_sleep_exit <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {clk, ce, resetn, clkmon_enable, supply_below, clock_valid} = 6'b010000;
        {sleep_mode, deep_sleep_exit, sw_reset, reg_wr, reg_rd} = 5'b0;
        {reset_config_word, reg_wdata, reg_addr, initial_osc_select} = '0;
        errors = 0;
        checks = 0;
        cyc    = 0;
        void'($urandom(4362));
        lvl = 2'($urandom % 3);
        initial_osc_select = 3'($urandom);

        // power-on: timer extends release, flags and reset values
        por(mk_cfg(lvl, 2'b11, 1'b1), 1'b1, 1'b0);
        wait_rst(1'b0, n);
        chk_cnt(n, PW, PW + 8);
        chk_word({14'h0, trip_level}, {14'h0, lvl});
        repeat (6) @(posedge clk);
        #1;
        chk_bit(exec_enable, 1'b1);
        rd(brs_pkg::ADDR_RCAUSE, rv);
        chk_word(rv, brs_pkg::RCAUSE_POR_VAL);
        rd(brs_pkg::ADDR_CALIB, rv);
        chk_word(rv, brs_pkg::CALIB_RST_VAL);
        rd(brs_pkg::ADDR_NVCTL, rv);
        chk_word(rv, brs_pkg::NVCTL_RST_VAL);
        rd(brs_pkg::ADDR_CFG, rv);
        chk_word(rv, mk_cfg(lvl, 2'b11, 1'b1));
        rd(brs_pkg::ADDR_OSCCTL, rv);
        chk_word(rv, {13'h0, initial_osc_select});
        rd(4'hf, rv);
        chk_word(rv, 16'h0000);
        $display("test power-on done");

        // brown-out of random length, then flag and full delay
        wr(brs_pkg::ADDR_RCAUSE, 16'h0000);
        dip(5 + int'($urandom % 20), 1'b1, n);
        chk_cnt(n, PW, PW + 8);
        rd(brs_pkg::ADDR_RCAUSE, rv);
        chk_word(rv & 16'h0002, 16'h0002);
        // second dip restarts the timer; a third lands after it has counted part of its delay
        @(posedge clk);
        supply_below <= 1'b1;
        repeat (6) @(posedge clk);
        supply_below <= 1'b0;
        repeat (PW - 3) @(posedge clk);
        #1;
        chk_bit(internal_system_reset, 1'b1);
        dip(6, 1'b1, n);
        chk_cnt(n, PW, PW + 8);
        $display("test brown-out done");

        // timer disabled while brown-out stays on
        por(mk_cfg(lvl, 2'b11, 1'b0), 1'b1, 1'b0);
        wait_rst(1'b0, n);
        dip(8, 1'b1, n);
        chk_cnt(n, 0, PW - 1);
        $display("test timer off done");

        // every enable mode, with soft bit and sleep both clear, then both set
        for (int m = 0; m < 4; m++) begin
            por(mk_cfg(lvl, 2'(m), 1'b0), 1'b1, 1'b0);
            wait_rst(1'b0, n);
            for (int k = 0; k < 2; k++) begin
                wr(brs_pkg::ADDR_RCAUSE, 16'(k) << 13);
                rd(brs_pkg::ADDR_RCAUSE, rv);
                chk_bit(rv[13], k == 1 && m == 1);
                @(posedge clk);
                sleep_mode <= 1'(k);
                e = trips(2'(m), 1'(k), 1'(k));
                dip(8, e, n);
                @(posedge clk);
                sleep_mode <= 1'b0;
            end
        end
        $display("test modes done");

        // clock hold-off and monitor switching
        por(mk_cfg(lvl, 2'b11, 1'b0), 1'b0, 1'b0);
        repeat (30) @(posedge clk);
        #1;
        chk_bit(exec_enable, 1'b0);
        @(posedge clk);
        clock_valid <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk_bit(exec_enable, 1'b1);
        por(mk_cfg(lvl, 2'b11, 1'b0), 1'b0, 1'b1);
        repeat (40) @(posedge clk);
        #1;
        chk_bit(clk_switch_req, 1'b1);
        chk_word({13'h0, clk_switch_sel}, {13'h0, brs_pkg::OSC_FRC});
        por(mk_cfg(lvl, 2'b11, 1'b0), 1'b1, 1'b1);
        repeat (30) @(posedge clk);
        #1;
        chk_bit(clk_switch_req, 1'b0);
        @(posedge clk);
        clock_valid <= 1'b0;
        repeat (brs_pkg::CLKMON_WIN_CYC + 20) @(posedge clk);
        #1;
        chk_bit(clk_switch_req, 1'b1);
        chk_word({13'h0, clk_switch_sel}, {13'h0, brs_pkg::OSC_LOW_POWER_RC_OSC});
        $display("test clock monitor done");

        // calibration survives a software reset, not a power-on
        por(mk_cfg(lvl, 2'b11, 1'b0), 1'b1, 1'b0);
        wait_rst(1'b0, n);
        dcal = 16'($urandom);
        wr(brs_pkg::ADDR_CALIB, dcal);
        wr(brs_pkg::ADDR_RCAUSE, 16'h0000);
        pulse_sw(1'b1);
        wait_rst(1'b0, n);
        rd(brs_pkg::ADDR_CALIB, rv);
        chk_word(rv, dcal);
        rd(brs_pkg::ADDR_RCAUSE, rv);
        chk_word(rv & 16'h0040, 16'h0040);
        rd(brs_pkg::ADDR_OSCCTL, rv);
        chk_word(rv, {13'h0, initial_osc_select});
        wr(brs_pkg::ADDR_RCAUSE, 16'h0000);
        pulse_sw(1'b0);
        wait_rst(1'b0, n);
        rd(brs_pkg::ADDR_RCAUSE, rv);
        chk_word(rv & 16'h0003, 16'h0003);
        por(mk_cfg(lvl, 2'b11, 1'b0), 1'b1, 1'b0);
        rd(brs_pkg::ADDR_CALIB, rv);
        chk_word(rv, brs_pkg::CALIB_RST_VAL);
        $display("test register retention done");
        wrap_up();
    end
endmodule
